// file: rtl/spc_defines.vh
// constants for the serial port control block
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH
// register addresses in the special function register space
`define SPC_CTRL_ADDR 8'h98
`define SPC_BUF_ADDR 8'h99
`define SPC_CTRL_RESET 8'h00
// control register field positions
`define SPC_MODE_HI_BIT 7
`define SPC_MODE_LO_BIT 6
`define SPC_ADDR_FILT_BIT 5
`define SPC_RX_EN_BIT 4
`define SPC_TX_NINTH_BIT 3
`define SPC_RX_NINTH_BIT 2
`define SPC_TX_DONE_BIT 1
`define SPC_RX_DONE_BIT 0
// operating modes
`define SPC_MODE_SHIFT 2'b00
`define SPC_MODE_UART8 2'b01
`define SPC_MODE_UART9_FIX 2'b10
`define SPC_MODE_UART9_VAR 2'b11
// shift mode: one bit per 12 oscillator clocks, clock low for the first half
`define SPC_SHIFT_LAST 4'hb
`define SPC_SHIFT_HALF 4'h6
// fixed 9-bit mode: 16 ticks per bit, osc/64 gives 4 clocks a tick, osc/32 gives 2
`define SPC_FIX_LAST_SLOW 2'h3
`define SPC_FIX_LAST_FAST 2'h1
// oversampling: start checked at tick 7, later bits at tick 15
`define SPC_OVS_LAST 4'hf
`define SPC_OVS_START 4'h7
`endif

// file: rtl/spc_fifo.v
// receive byte fifo with registered head word
`timescale 1ns/1ps
`default_nettype none
module spc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire ref_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output reg out_valid_r,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data_r
);
    localparam [AW:0] FULL = DEPTH;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr_r;
    reg [AW-1:0] rptr_r;
    reg [AW:0] count_r;
    wire in_fire;
    wire out_fire;
    wire [AW-1:0] rptr_nxt;
    wire [AW:0] count_nxt;

    // handshakes and next pointers
    assign in_ready = (count_r != FULL);
    assign in_fire = in_valid & in_ready;
    assign out_fire = out_valid_r & out_ready;
    assign rptr_nxt = out_fire ? rptr_r + 1'b1 : rptr_r;
    assign count_nxt = count_r + {{AW{1'b0}}, in_fire} - {{AW{1'b0}}, out_fire};

    // storage array, no reset needed
    always @(posedge ref_clk) begin
        if (in_fire) begin
            mem[wptr_r] <= in_data;
        end
    end

    // pointers, level and registered head word with write bypass
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            wptr_r <= {AW{1'b0}};
            rptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
            out_valid_r <= 1'b0;
            out_data_r <= {WIDTH{1'b0}};
        end else begin
            if (in_fire) begin
                wptr_r <= wptr_r + 1'b1;
            end
            rptr_r <= rptr_nxt;
            count_r <= count_nxt;
            out_valid_r <= (count_nxt != {(AW+1){1'b0}});
            out_data_r <= (in_fire && wptr_r == rptr_nxt) ? in_data : mem[rptr_nxt];
        end
    end
endmodule // spc_fifo
`default_nettype wire

// file: rtl/spc_top.v
// serial port with four modes behind the control and buffer registers
`timescale 1ns/1ps
`default_nettype none
`include "spc_defines.vh"
module spc_top (
    input wire ref_clk,
    input wire rst_n,
    input wire [7:0] sfr_addr,
    input wire sfr_wr_en,
    input wire sfr_rd_en,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata_r,
    input wire timer_one_ovf,
    input wire timer_two_ovf,
    input wire timer_two_rx_baud_select,
    input wire timer_two_tx_baud_select,
    input wire double_baud,
    output reg txd_r,
    input wire rxd_in,
    output wire rxd_out,
    output wire rxd_oe
);
    localparam R_IDLE = 3'd0;
    localparam R_START = 3'd1;
    localparam R_DATA = 3'd2;
    localparam R_STOP = 3'd3;
    localparam R_SHIFT = 3'd4;

    // baud tick source: fixed prescaler in mode 2, timer one or two otherwise
    function sel_tick;
        input [1:0] mode;
        input use_t2;
        input t1_tick;
        input t2_tick;
        input fix_tick;
        begin
            if (mode == `SPC_MODE_UART9_FIX) begin
                sel_tick = fix_tick;
            end else begin
                sel_tick = use_t2 ? t2_tick : t1_tick;
            end
        end
    endfunction

    reg [7:0] ctrl_r;
    reg rxd_s1_r, rxd_s2_r, rxd_s3_r;
    reg t1_half_r;
    reg [1:0] fix_cnt_r;
    reg [3:0] sh_cnt_r;
    reg [2:0] rx_state_r;
    reg [3:0] rx_os_r;
    reg [3:0] rx_bit_r;
    reg [8:0] rx_sh_r;
    reg tx_pend_r;
    reg [7:0] tx_data_r;
    reg tx_busy_r;
    reg [10:0] tx_sh_r;
    reg [3:0] tx_left_r;
    reg [3:0] tx_os_r;
    reg rx_push, rx_done_set, tx_done_set;
    reg rb8_load, rb8_val;
    wire [1:0] mode;
    wire is_shift, is_nine, filt, ren;
    wire t1_tick, fix_tick, rx_tick, tx_tick, sh_end;
    wire fifo_ready, fifo_valid;
    wire [7:0] fifo_data;
    wire buf_rd, buf_wr, ctrl_wr;
    wire [7:0] rx_byte;

    assign mode = {ctrl_r[`SPC_MODE_HI_BIT], ctrl_r[`SPC_MODE_LO_BIT]};
    assign is_shift = (mode == `SPC_MODE_SHIFT);
    assign is_nine = mode[1];
    assign filt = ctrl_r[`SPC_ADDR_FILT_BIT];
    assign ren = ctrl_r[`SPC_RX_EN_BIT];
    assign ctrl_wr = sfr_wr_en && (sfr_addr == `SPC_CTRL_ADDR);
    assign buf_wr = sfr_wr_en && (sfr_addr == `SPC_BUF_ADDR);
    assign buf_rd = sfr_rd_en && (sfr_addr == `SPC_BUF_ADDR);
    assign sh_end = (sh_cnt_r == `SPC_SHIFT_LAST);
    // timer one overflow halved unless the rate is doubled
    assign t1_tick = timer_one_ovf & (double_baud | t1_half_r);
    assign fix_tick = (fix_cnt_r == (double_baud ? `SPC_FIX_LAST_FAST : `SPC_FIX_LAST_SLOW));
    assign rx_tick = sel_tick(mode, timer_two_rx_baud_select, t1_tick, timer_two_ovf, fix_tick);
    assign tx_tick = sel_tick(mode, timer_two_tx_baud_select, t1_tick, timer_two_ovf, fix_tick);
    assign rx_byte = is_nine ? rx_sh_r[7:0] : rx_sh_r[8:1];
    // shift mode drives data out on the receive line while sending
    assign rxd_out = tx_sh_r[0];
    assign rxd_oe = tx_busy_r & is_shift;

    // received bytes wait here until software reads the buffer
    spc_fifo #(.WIDTH(8), .DEPTH(32), .AW(5)) u_rx_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(rx_push),
        .in_ready(fifo_ready),
        .in_data(rx_byte),
        .out_valid_r(fifo_valid),
        .out_ready(buf_rd),
        .out_data_r(fifo_data)
    );

    // input synchroniser, prescalers and register read data
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rxd_s1_r <= 1'b1;
            rxd_s2_r <= 1'b1;
            rxd_s3_r <= 1'b1;
            t1_half_r <= 1'b0;
            fix_cnt_r <= 2'h0;
            sh_cnt_r <= 4'h0;
            sfr_rdata_r <= 8'h00;
        end else begin
            rxd_s1_r <= rxd_in;
            rxd_s2_r <= rxd_s1_r;
            rxd_s3_r <= rxd_s2_r;
            if (timer_one_ovf) begin
                t1_half_r <= ~t1_half_r;
            end
            fix_cnt_r <= fix_tick ? 2'h0 : fix_cnt_r + 2'h1;
            sh_cnt_r <= sh_end ? 4'h0 : sh_cnt_r + 4'h1;
            if (sfr_rd_en && sfr_addr == `SPC_CTRL_ADDR) begin
                sfr_rdata_r <= ctrl_r;
            end else if (buf_rd) begin
                sfr_rdata_r <= fifo_valid ? fifo_data : 8'h00;
            end else begin
                sfr_rdata_r <= 8'h00;
            end
        end
    end

    // receiver: async frames with oversampling, or clocked shift mode
    always @(posedge ref_clk) begin
        // registered one-cycle pulses, so the fifo and control register see them
        rx_push <= 1'b0;
        rx_done_set <= 1'b0;
        rb8_load <= 1'b0;
        rb8_val <= 1'b0;
        if (!rst_n) begin
            rx_state_r <= R_IDLE;
            rx_os_r <= 4'h0;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 9'h000;
        end else if (!ren) begin
            rx_state_r <= R_IDLE;
        end else begin
            case (rx_state_r)
                R_IDLE: begin
                    rx_os_r <= 4'h0;
                    rx_bit_r <= 4'h0;
                    if (is_shift) begin
                        if (!ctrl_r[`SPC_RX_DONE_BIT] && fifo_ready && !tx_busy_r && !tx_pend_r
                            && sh_end) begin
                            rx_state_r <= R_SHIFT;
                        end
                    end else if (fifo_ready && rxd_s3_r && !rxd_s2_r) begin
                        rx_state_r <= R_START;
                    end
                end
                R_START: begin
                    if (rx_tick) begin
                        rx_os_r <= rx_os_r + 4'h1;
                        if (rx_os_r == `SPC_OVS_START) begin
                            rx_os_r <= 4'h0;
                            rx_state_r <= rxd_s2_r ? R_IDLE : R_DATA;
                        end
                    end
                end
                R_DATA: begin
                    if (rx_tick) begin
                        rx_os_r <= rx_os_r + 4'h1;
                        if (rx_os_r == `SPC_OVS_LAST) begin
                            rx_sh_r <= {rxd_s2_r, rx_sh_r[8:1]};
                            rx_bit_r <= rx_bit_r + 4'h1;
                            if (rx_bit_r == (is_nine ? 4'h8 : 4'h7)) begin
                                rx_state_r <= R_STOP;
                            end
                        end
                    end
                end
                R_STOP: begin
                    if (rx_tick) begin
                        rx_os_r <= rx_os_r + 4'h1;
                        if (rx_os_r == `SPC_OVS_LAST) begin
                            rx_state_r <= R_IDLE;
                            if (is_nine) begin
                                if (!filt || rx_sh_r[8]) begin
                                    rx_push <= 1'b1;
                                    rx_done_set <= 1'b1;
                                    rb8_load <= 1'b1;
                                    rb8_val <= rx_sh_r[8];
                                end
                            end else if (!filt || rxd_s2_r) begin
                                rx_push <= 1'b1;
                                rx_done_set <= 1'b1;
                                rb8_load <= 1'b1;
                                rb8_val <= rxd_s2_r;
                            end
                        end
                    end
                end
                R_SHIFT: begin
                    // sample on the rising clock edge, shift mode leaves the ninth bit alone
                    if (sh_cnt_r == `SPC_SHIFT_HALF) begin
                        rx_sh_r <= {rxd_s2_r, rx_sh_r[8:1]};
                    end
                    if (sh_end) begin
                        rx_bit_r <= rx_bit_r + 4'h1;
                        if (rx_bit_r == 4'h7) begin
                            rx_state_r <= R_IDLE;
                            rx_push <= 1'b1;
                            rx_done_set <= 1'b1;
                        end
                    end
                end
                default: begin
                    rx_state_r <= R_IDLE;
                end
            endcase
        end
    end

    // transmitter: a buffer write queues a byte, which starts when the engine is free
    always @(posedge ref_clk) begin
        tx_done_set <= 1'b0;
        if (!rst_n) begin
            tx_pend_r <= 1'b0;
            tx_data_r <= 8'h00;
            tx_busy_r <= 1'b0;
            tx_sh_r <= 11'h7ff;
            tx_left_r <= 4'h0;
            tx_os_r <= 4'h0;
            txd_r <= 1'b1;
        end else begin
            if (buf_wr) begin
                tx_pend_r <= 1'b1;
                tx_data_r <= sfr_wdata;
            end
            if (!tx_busy_r) begin
                tx_os_r <= 4'h0;
                if (tx_pend_r && !buf_wr) begin
                    if (!is_shift) begin
                        tx_busy_r <= 1'b1;
                        tx_pend_r <= 1'b0;
                        // start, data lsb first, ninth or stop, stop
                        tx_sh_r <= {1'b1, is_nine ? ctrl_r[`SPC_TX_NINTH_BIT] : 1'b1,
                                    tx_data_r, 1'b0};
                        tx_left_r <= is_nine ? 4'hb : 4'ha;
                    end else if (sh_end && rx_state_r != R_SHIFT) begin
                        tx_busy_r <= 1'b1;
                        tx_pend_r <= 1'b0;
                        tx_sh_r <= {3'h7, tx_data_r};
                        tx_left_r <= 4'h8;
                    end
                end
            end else if (is_shift ? sh_end : (tx_tick && tx_os_r == `SPC_OVS_LAST)) begin
                tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                tx_left_r <= tx_left_r - 4'h1;
                // restart the tick count so every bit outside shift mode lasts sixteen ticks
                tx_os_r <= 4'h0;
                if (tx_left_r == 4'h1) begin
                    tx_busy_r <= 1'b0;
                    tx_done_set <= 1'b1;
                end
            end else if (tx_tick) begin
                tx_os_r <= tx_os_r + 4'h1;
            end
            // line drive: shift clock in mode 0, frame bits otherwise
            if (!tx_busy_r && rx_state_r != R_SHIFT) begin
                txd_r <= 1'b1;
            end else if (is_shift) begin
                txd_r <= (sh_cnt_r >= `SPC_SHIFT_HALF);
            end else begin
                txd_r <= tx_sh_r[0];
            end
        end
    end

    // control register: hardware set of a done flag wins over a software clear
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_r <= `SPC_CTRL_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl_r <= sfr_wdata;
            end
            if (rb8_load) begin
                ctrl_r[`SPC_RX_NINTH_BIT] <= rb8_val;
            end
            if (tx_done_set) begin
                ctrl_r[`SPC_TX_DONE_BIT] <= 1'b1;
            end
            if (rx_done_set) begin
                ctrl_r[`SPC_RX_DONE_BIT] <= 1'b1;
            end
        end
    end
endmodule // spc_top
`default_nettype wire

// file: testbench/spc_chk.sv
// assertion checker for the serial port control block
`timescale 1ns/1ps
`default_nettype none
`include "spc_defines.vh"
module spc_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic sfr_rd_en,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata_r,
    input wire logic txd_r,
    input wire logic rxd_oe
);
    // one clock domain, reset low disables every check
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // decoded strobes and the last control byte written
    wire ctl_wr = sfr_wr_en && sfr_addr == `SPC_CTRL_ADDR;
    wire ctl_rd = sfr_rd_en && sfr_addr == `SPC_CTRL_ADDR;
    wire buf_wr = sfr_wr_en && sfr_addr == `SPC_BUF_ADDR;
    wire odd_rd = sfr_rd_en && sfr_addr != `SPC_CTRL_ADDR && sfr_addr != `SPC_BUF_ADDR;
    logic [7:0] ctl_w_r;
    always_ff @(posedge ref_clk)
        if (ctl_wr) ctl_w_r <= sfr_wdata;
    AST_IDLE_RESET: assert property ($rose(rst_n) |-> txd_r && !rxd_oe)
        else $error("line not idle after reset");
    AST_RDATA_IDLE: assert property (!sfr_rd_en |=> sfr_rdata_r == 8'h00)
        else $error("read data not cleared");
    AST_UNMAPPED: assert property (odd_rd |=> sfr_rdata_r == 8'h00)
        else $error("unmapped read not zero");
    AST_READBACK: assert property (ctl_wr ##1 ctl_rd |=> sfr_rdata_r[7:3] == ctl_w_r[7:3])
        else $error("control bits not read back");
    AST_START_LOW: assert property ($fell(txd_r) && !rxd_oe |-> !txd_r [*6])
        else $error("start bit too short");
    AST_SHIFT_LOW: assert property ($fell(txd_r) && rxd_oe |-> !txd_r [*6] ##1 txd_r)
        else $error("shift clock low phase wrong");
    AST_SHIFT_HIGH: assert property ($rose(txd_r) && rxd_oe |-> txd_r [*6])
        else $error("shift clock high phase wrong");
    AST_TX_START: assert property (buf_wr && !rxd_oe && txd_r |-> ##[1:20] !txd_r)
        else $error("transmission did not start");
    AST_OE_END: assert property ($fell(rxd_oe) |-> txd_r)
        else $error("shift clock left low");
    // main scenarios reached
    cover property (ctl_rd ##1 sfr_rdata_r[1]);
    cover property (ctl_rd ##1 sfr_rdata_r[0]);
    cover property ($fell(txd_r) && rxd_oe);
endmodule // spc_chk
bind spc_top spc_chk spc_chk_inst (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata),
    .sfr_rdata_r(sfr_rdata_r), .txd_r(txd_r), .rxd_oe(rxd_oe));
`default_nettype wire

// file: testbench/spc_remote.sv
// remote serial device model on the transmit and receive lines
`timescale 1ns/1ps
`default_nettype none
module spc_remote #(
    parameter BIT_CLKS = 32
) (
    input wire logic ref_clk,
    input wire logic txd,
    output logic rxd
);
    // line idles high between frames
    initial rxd = 1'b1;
    // start bit, n bits lsb first, then one idle bit time
    task automatic send(input logic [9:0] bits, input int n);
        int i;
        @(posedge ref_clk) #1 rxd = 1'b0;
        repeat (BIT_CLKS) @(posedge ref_clk);
        for (i = 0; i < n; i++) begin
            #1 rxd = bits[i];
            repeat (BIT_CLKS) @(posedge ref_clk);
        end
        #1 rxd = 1'b1;
        repeat (BIT_CLKS) @(posedge ref_clk);
    endtask
    // wait for a start edge, then sample ten bits at their centres
    task automatic recv(output logic [9:0] bits, output logic ok);
        int k;
        ok = 1'b0;
        bits = 10'h000;
        for (k = 0; k < 200 && !ok; k++) begin
            @(posedge ref_clk);
            ok = (txd === 1'b0);
        end
        if (ok) begin
            repeat (BIT_CLKS / 2) @(posedge ref_clk);
            for (k = 0; k < 10; k++) begin
                repeat (BIT_CLKS) @(posedge ref_clk);
                bits[k] = txd;
            end
        end
    endtask
endmodule // spc_remote
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
`include "spc_defines.vh"
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr_en = 1'b0;
    logic sfr_rd_en = 1'b0;
    logic tick = 1'b0;
    logic t1_on = 1'b1;
    logic rx_t2 = 1'b0;
    logic tx_t2 = 1'b0;
    wire [7:0] sfr_rdata_r;
    wire txd_r;
    wire rxd_out;
    wire rxd_oe;
    wire remote_rxd;
    wire rxd_in;
    int num_errors = 0;
    int n_checks = 0;
    // 50 MHz clock and a timer overflow every second cycle
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) #1 tick = ~tick;
    // the receive pin follows whichever side drives it
    assign rxd_in = rxd_oe ? rxd_out : remote_rxd;
    spc_top spc_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata),
        .sfr_rdata_r(sfr_rdata_r), .timer_one_ovf(tick & t1_on), .timer_two_ovf(tick),
        .timer_two_rx_baud_select(rx_t2), .timer_two_tx_baud_select(tx_t2),
        .double_baud(1'b1), .txd_r(txd_r), .rxd_in(rxd_in), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe));
    spc_remote spc_remote_inst (.ref_clk(ref_clk), .txd(txd_r), .rxd(remote_rxd));
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 rst_n = 1'b1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr_en = 1'b1;
        @(posedge ref_clk) #1;
        sfr_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk) #1;
        sfr_addr = a;
        sfr_rd_en = 1'b1;
        @(posedge ref_clk) #1;
        sfr_rd_en = 1'b0;
        d = sfr_rdata_r;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    // poll the control register until a flag rises, bounded
    task automatic wait_ctl(input logic [7:0] m);
        logic [7:0] d;
        int k;
        d = 8'h00;
        for (k = 0; k < 2000 && (d & m) !== m; k++)
            rd(`SPC_CTRL_ADDR, d);
        chk(d & m, m);
        if ((d & m) !== m) conclude();
    endtask
    task automatic t_reset();
        rdc(`SPC_CTRL_ADDR, `SPC_CTRL_RESET);
        rdc(8'h55, 8'h00);
        rdc(`SPC_BUF_ADDR, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_tx(input logic [1:0] m, input logic n9, input logic [7:0] v, input logic s2);
        logic [9:0] f;
        logic ok;
        tx_t2 = s2;
        t1_on = !s2;
        wr(`SPC_CTRL_ADDR, {m, 2'b00, n9, 3'b000});
        fork
            spc_remote_inst.recv(f, ok);
            wr(`SPC_BUF_ADDR, v);
        join
        chk({7'h00, ok}, 8'h01);
        chk(f[7:0], v);
        chk({6'h00, f[9:8]}, {7'h01, m == 2'b01 ? 1'b1 : n9});
        wait_ctl(8'h02);
        tx_t2 = 1'b0;
        t1_on = 1'b1;
        $display("test tx mode %0d done", m);
    endtask
    task automatic t_rx(input logic [1:0] m, input logic fl, input logic s2);
        logic [7:0] c;
        int n;
        c = {m, fl, 1'b1, 4'h0};
        n = (m == 2'b01) ? 9 : 10;
        rx_t2 = s2;
        t1_on = !s2;
        wr(`SPC_CTRL_ADDR, c);
        spc_remote_inst.send(m == 2'b01 ? 10'h05a : 10'h2a5, n);
        rdc(`SPC_CTRL_ADDR, fl ? c : c | 8'h01);
        if (!fl) begin
            rdc(`SPC_BUF_ADDR, 8'ha5);
            wr(`SPC_CTRL_ADDR, c);
        end
        spc_remote_inst.send(m == 2'b01 ? 10'h13c : 10'h33c, n);
        rdc(`SPC_CTRL_ADDR, c | 8'h05);
        rdc(`SPC_BUF_ADDR, 8'h3c);
        rx_t2 = 1'b0;
        t1_on = 1'b1;
        $display("test rx mode %0d done", m);
    endtask
    task automatic t_rx_off();
        wr(`SPC_CTRL_ADDR, 8'h80);
        spc_remote_inst.send(10'h2a5, 10);
        rdc(`SPC_CTRL_ADDR, 8'h80);
        rdc(`SPC_BUF_ADDR, 8'h00);
        $display("test rx off done");
    endtask
    task automatic t_fifo();
        int i;
        wr(`SPC_CTRL_ADDR, 8'h90);
        for (i = 0; i < 33; i++)
            spc_remote_inst.send({2'b10, i[7:0]}, 10);
        for (i = 0; i < 32; i++)
            rdc(`SPC_BUF_ADDR, i[7:0]);
        rdc(`SPC_BUF_ADDR, 8'h00);
        $display("test fifo done");
    endtask
    task automatic t_shift();
        logic [7:0] v;
        int i;
        int k;
        v = 8'h00;
        wr(`SPC_CTRL_ADDR, 8'h00);
        wr(`SPC_BUF_ADDR, 8'h96);
        for (i = 0; i < 8; i++) begin
            for (k = 0; k < 40 && !(rxd_oe === 1'b1 && txd_r === 1'b0); k++)
                @(posedge ref_clk) #1;
            for (k = 0; k < 40 && txd_r !== 1'b1; k++)
                @(posedge ref_clk) #1;
            v[i] = rxd_out;
        end
        chk(v, 8'h96);
        wait_ctl(8'h02);
        $display("test shift done");
    endtask
    // main sequence, ending with a second reset once the shift test has finished and the port is idle
    initial begin
        do_reset();
        t_reset();
        t_tx(2'b10, 1'b1, 8'h5a, 1'b0);
        t_tx(2'b11, 1'b0, 8'hc3, 1'b0);
        t_tx(2'b01, 1'b0, 8'h81, 1'b1);
        t_rx(2'b11, 1'b1, 1'b1);
        t_rx(2'b10, 1'b0, 1'b0);
        t_rx(2'b01, 1'b1, 1'b0);
        t_rx_off();
        t_fifo();
        t_shift();
        do_reset();
        t_reset();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
